// ==== core/maas_pkg.sv ====
// Purpose: constants and carriers for the mac helper sequencer
// Assumes: 8-bit register port, byte-wide registers
// Notes:   offsets other than the filter config are local choices
package maas_pkg;

    // register offsets (byte index)
    localparam logic [7:0] ADDR_AFC0     = 8'h00;
    localparam logic [7:0] ADDR_CTRL     = 8'h01;
    localparam logic [7:0] ADDR_ACK_DL   = 8'h02;
    localparam logic [7:0] ADDR_ACK_DH   = 8'h03;
    localparam logic [7:0] ADDR_ACK_PD   = 8'h04;
    localparam logic [7:0] ADDR_THRESH   = 8'h05;
    localparam logic [7:0] ADDR_TXLEN_L  = 8'h06;
    localparam logic [7:0] ADDR_TXLEN_H  = 8'h07;
    localparam logic [7:0] ADDR_ED_MODE  = 8'h08;
    localparam logic [7:0] ADDR_BB       = 8'h09;
    localparam logic [7:0] ADDR_STATUS   = 8'h0A;

    // control and filter config bit positions, filter unit count
    localparam int CTRL_TRANSMIT_THEN_RECEIVE  = 0;
    localparam int CTRL_ENERGY_DETECT_AUTO_TRANSMIT  = 1;
    localparam int CTRL_CHRES  = 2;
    localparam int CTRL_AUTO_ACK_ENABLE   = 3;
    localparam int CTRL_SRC    = 4;
    localparam int CTRL_DR     = 5;
    localparam int CTRL_FA     = 6;
    localparam int AFC0_PM     = 4;
    localparam int FILT_UNITS  = 4;

    localparam logic [1:0] ED_MODE_SINGLE = 2'h1;
    localparam logic [2:0] FT_DATA        = 3'h1;
    localparam logic [2:0] FT_CMD         = 3'h3;
    localparam logic [10:0] ACK_LEN_FCS16 = 11'h005;
    localparam logic [10:0] ACK_LEN_FCS32 = 11'h007;
    localparam logic [7:0]  RESET_BYTE    = 8'h00;

    typedef enum logic [2:0] {
        MAAS_IDLE,
        MAAS_ACK_WAIT,
        MAAS_ACK_TX,
        MAAS_ED_RUN,
        MAAS_CCA_TX
    } maas_state_t;

    // received frame facts from the filter and demodulator
    typedef struct packed {
        logic                  frame_end;
        logic                  passed;
        logic [2:0]            frame_type;
        logic                  ack_req;
        logic [3:0]            unit_match;
        logic [7:0]            seq_num;
        logic                  fcs32;
        logic [7:0]            phr;
    } maas_rx_t;

    // ack / frame transmit request toward the transmitter
    typedef struct packed {
        logic                  start;
        logic                  from_buffer;
        logic [10:0]           length;
        logic [7:0]            seq_num;
        logic                  pending;
        logic                  fcs32;
        logic                  phr_override;
        logic [7:0]            phr;
    } maas_tx_t;

endpackage

// ==== core/maas_seq.sv ====
// Purpose: auto-ack, transmit-then-receive and cca auto-transmit sequencer
// Assumes: single 25 MHz clock, sync active-high reset, host keeps its side
// Notes:   phy override image is carried as one byte; transmitter restores
//
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/10ps
`default_nettype none

// Contract
// - auto ack needs enable and filter enabled
// - ack only passed data/cmd frames requesting ack
// - rx end irq only for passed frames
// - ack starts programmed delay after rx end
// - rate adapt overrides phy for ack only
// - copy received mcs, sfd or oqpsk settings
// - checksum type follows rx frame
// - source 0: self-built ack, 5 or 7
// - source 1: buffer ack with tx length
// - pending bit from matching filter unit
// - tx end irq after ack sent
// - no-ack frame ends with rx end; here it stays in prepare until an ack or clear-channel tx end
// - transmit-then-receive enters receive after tx
// - mode write 0x1 starts one measurement
// - busy: flag set, tx end, no tx
// - clear: flag cleared, prepare then transmit
// - transceiver ready at transmit prepare; here raised only on the clear-channel path, not when auto ack enters prepare
// - clear channel re-enables baseband
// - promiscuous field 0 off, 1 on
// - filter enable n enables unit n
module maas_seq #(
    parameter int DELAY_W = 16
) (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic [7:0]           addr_i,
    input  wire logic [7:0]           wdata_i,
    input  wire logic                 wr_i,
    input  wire logic                 rd_i,
    output var  logic [7:0]           rdata_o,
    input  wire maas_pkg::maas_rx_t   rx_i,
    input  wire logic                 in_rx_state_i,
    input  wire logic                 tx_done_i,
    input  wire logic                 ed_done_i,
    input  wire logic [7:0]           ed_value_i,
    output var  maas_pkg::maas_tx_t   tx_o,
    output var  logic                 ed_start_o,
    output var  logic                 rx_enter_o,
    output var  logic                 rx_frame_end_irq_o,
    output var  logic                 transmit_frame_end_irq_o,
    output var  logic                 measurement_done_irq_o,
    output var  logic                 transceiver_ready_irq_o,
    output var  logic                 transmit_prepare_state_o,
    output var  logic                 baseband_enable_o,
    output var  logic                 promiscuous_select_o,
    output var  logic [3:0]           filter_unit_enable_o
);

    typedef struct packed {
        maas_pkg::maas_state_t st;
        logic [7:0]            afc0;
        logic [7:0]            ctrl;
        logic [7:0]            dly_l;
        logic [7:0]            dly_h;
        logic [7:0]            pend;
        logic [7:0]            thresh;
        logic [7:0]            len_l;
        logic [7:0]            len_h;
        logic                  bb_en;
        logic [DELAY_W-1:0]    cnt;
        maas_pkg::maas_rx_t    held;
        maas_pkg::maas_tx_t    tx;
        logic [7:0]            rdata;
        logic                  ed_start;
        logic                  rx_enter;
        logic                  rxfe;
        logic                  transmit_frame_end_irq;
        logic                  edc;
        logic                  transceiver_ready_irq;
        logic                  prep;
    } maas_regs_t;

    maas_regs_t r;
    maas_regs_t next_r;

    // pending bit of the lowest matching unit
    function automatic logic pend_of(input logic [3:0] m,
                                     input logic [3:0] pd);
        logic res;
        res = 1'b0;
        for (int i = maas_pkg::FILT_UNITS - 1; i >= 0; i--) begin
            if (m[i]) begin
                res = pd[i];
            end
        end
        return res;
    endfunction

    logic filt_on;
    logic ack_need;
    logic rx_ok;
    always_comb begin
        filt_on  = |r.afc0[maas_pkg::FILT_UNITS-1:0];
        rx_ok    = rx_i.frame_end && rx_i.passed;
        ack_need = (rx_i.frame_type == maas_pkg::FT_DATA
                    || rx_i.frame_type == maas_pkg::FT_CMD)
                   && rx_i.ack_req
                   && |(rx_i.unit_match & r.afc0[3:0]);
    end

    always_comb begin
        next_r          = r;
        next_r.rdata    = maas_pkg::RESET_BYTE;
        next_r.ed_start = 1'b0;
        next_r.rx_enter = 1'b0;
        next_r.rxfe     = 1'b0;
        next_r.transmit_frame_end_irq     = 1'b0;
        next_r.edc      = 1'b0;
        next_r.transceiver_ready_irq   = 1'b0;
        next_r.tx.start = 1'b0;
        if (wr_i) begin
            unique case (addr_i)
                maas_pkg::ADDR_AFC0:    next_r.afc0   = wdata_i;
                maas_pkg::ADDR_CTRL: begin
                    // result flag is read-only
                    next_r.ctrl = wdata_i;
                    next_r.ctrl[maas_pkg::CTRL_CHRES] =
                        r.ctrl[maas_pkg::CTRL_CHRES];
                end
                maas_pkg::ADDR_ACK_DL:  next_r.dly_l  = wdata_i;
                maas_pkg::ADDR_ACK_DH:  next_r.dly_h  = wdata_i;
                maas_pkg::ADDR_ACK_PD:  next_r.pend   = wdata_i;
                maas_pkg::ADDR_THRESH:  next_r.thresh = wdata_i;
                maas_pkg::ADDR_TXLEN_L: next_r.len_l  = wdata_i;
                maas_pkg::ADDR_TXLEN_H: next_r.len_h  = wdata_i;
                maas_pkg::ADDR_BB:      next_r.bb_en  = wdata_i[0];
                maas_pkg::ADDR_ED_MODE: begin
                    // single measurement only from receive, idle
                    if (wdata_i[1:0] == maas_pkg::ED_MODE_SINGLE
                        && r.ctrl[maas_pkg::CTRL_ENERGY_DETECT_AUTO_TRANSMIT]
                        && in_rx_state_i
                        && r.st == maas_pkg::MAAS_IDLE) begin
                        next_r.ed_start = 1'b1;
                        next_r.st       = maas_pkg::MAAS_ED_RUN;
                    end
                end
                default: ;
            endcase
        end
        if (rd_i) begin
            unique case (addr_i)
                maas_pkg::ADDR_AFC0:    next_r.rdata = r.afc0;
                maas_pkg::ADDR_CTRL:    next_r.rdata = r.ctrl;
                maas_pkg::ADDR_ACK_DL:  next_r.rdata = r.dly_l;
                maas_pkg::ADDR_ACK_DH:  next_r.rdata = r.dly_h;
                maas_pkg::ADDR_ACK_PD:  next_r.rdata = r.pend;
                maas_pkg::ADDR_THRESH:  next_r.rdata = r.thresh;
                maas_pkg::ADDR_TXLEN_L: next_r.rdata = r.len_l;
                maas_pkg::ADDR_TXLEN_H: next_r.rdata = r.len_h;
                maas_pkg::ADDR_BB:      next_r.rdata = {7'h00, r.bb_en};
                maas_pkg::ADDR_STATUS:  next_r.rdata = {4'h0, r.prep,
                                                        r.st};
                default:                next_r.rdata = maas_pkg::RESET_BYTE;
            endcase
        end

        unique case (r.st)
            maas_pkg::MAAS_IDLE: begin
                if (rx_ok) begin
                    next_r.rxfe = 1'b1;
                    if (r.ctrl[maas_pkg::CTRL_AUTO_ACK_ENABLE] && filt_on) begin
                        // a no-ack frame ends here still in prepare;
                        // only an ack or clear-channel transmit end clears it again
                        next_r.prep = 1'b1;
                        if (ack_need) begin
                            next_r.held = rx_i;
                            next_r.cnt = DELAY_W'({r.dly_h, r.dly_l});
                            next_r.st  = maas_pkg::MAAS_ACK_WAIT;
                        end
                    end
                end
            end
            maas_pkg::MAAS_ACK_WAIT: begin
                // host must fill the buffer before zero
                if (r.cnt == '0) begin
                    next_r.tx.start       = 1'b1;
                    next_r.tx.from_buffer = r.ctrl[maas_pkg::CTRL_SRC];
                    next_r.tx.seq_num     = r.held.seq_num;
                    next_r.tx.fcs32 = r.ctrl[maas_pkg::CTRL_FA]
                                      && r.held.fcs32;
                    if (r.ctrl[maas_pkg::CTRL_SRC]) begin
                        next_r.tx.length = {r.len_h[2:0], r.len_l};
                    end else begin
                        next_r.tx.length = next_r.tx.fcs32
                            ? maas_pkg::ACK_LEN_FCS32
                            : maas_pkg::ACK_LEN_FCS16;
                    end
                    next_r.tx.pending = pend_of(r.held.unit_match,
                                                r.pend[3:0]);
                    // transmitter applies phr only while flagged
                    next_r.tx.phr_override = r.ctrl[maas_pkg::CTRL_DR];
                    next_r.tx.phr = r.held.phr;
                    next_r.st = maas_pkg::MAAS_ACK_TX;
                end else begin
                    next_r.cnt = r.cnt - 1'b1;
                end
            end
            maas_pkg::MAAS_ACK_TX, maas_pkg::MAAS_CCA_TX: begin
                if (tx_done_i) begin
                    next_r.transmit_frame_end_irq            = 1'b1;
                    next_r.prep            = 1'b0;
                    next_r.tx.phr_override = 1'b0;
                    next_r.st              = maas_pkg::MAAS_IDLE;
                end
            end
            maas_pkg::MAAS_ED_RUN: begin
                if (ed_done_i) begin
                    next_r.edc = 1'b1;
                    if (ed_value_i > r.thresh) begin
                        next_r.ctrl[maas_pkg::CTRL_CHRES] = 1'b1;
                        next_r.transmit_frame_end_irq = 1'b1;
                        next_r.st   = maas_pkg::MAAS_IDLE;
                    end else begin
                        next_r.ctrl[maas_pkg::CTRL_CHRES] = 1'b0;
                        next_r.bb_en  = 1'b1;
                        next_r.prep   = 1'b1;
                        next_r.transceiver_ready_irq = 1'b1;
                        next_r.tx.start        = 1'b1;
                        next_r.tx.from_buffer  = 1'b1;
                        next_r.tx.length = {r.len_h[2:0], r.len_l};
                        next_r.tx.phr_override = 1'b0;
                        next_r.st = maas_pkg::MAAS_CCA_TX;
                    end
                end
            end
            default: next_r.st = maas_pkg::MAAS_IDLE;
        endcase

        // plain transmissions finish into receive when asked
        if (tx_done_i && r.ctrl[maas_pkg::CTRL_TRANSMIT_THEN_RECEIVE]) begin
            next_r.rx_enter = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    always_comb begin
        rdata_o                  = r.rdata;
        tx_o                     = r.tx;
        ed_start_o               = r.ed_start;
        rx_enter_o               = r.rx_enter;
        rx_frame_end_irq_o       = r.rxfe;
        transmit_frame_end_irq_o = r.transmit_frame_end_irq;
        measurement_done_irq_o   = r.edc;
        transceiver_ready_irq_o  = r.transceiver_ready_irq;
        transmit_prepare_state_o = r.prep;
        baseband_enable_o        = r.bb_en;
        promiscuous_select_o     = r.afc0[maas_pkg::AFC0_PM];
        filter_unit_enable_o     = r.afc0[3:0];
    end

    default clocking cb_main @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    chk_rxfe_needs_pass: assert property (
        rx_frame_end_irq_o |-> $past(rx_i.frame_end && rx_i.passed))
        else $error("rx end irq without passed frame");
    chk_busy_no_tx: assert property (
        (r.st == maas_pkg::MAAS_ED_RUN && ed_done_i && ed_value_i > r.thresh)
        |=> transmit_frame_end_irq_o && !tx_o.start
            && r.ctrl[maas_pkg::CTRL_CHRES])
        else $error("busy channel handled wrongly");
    chk_clear_tx: assert property (
        (r.st == maas_pkg::MAAS_ED_RUN && ed_done_i && ed_value_i <= r.thresh)
        |=> tx_o.start && transceiver_ready_irq_o && baseband_enable_o
            && !r.ctrl[maas_pkg::CTRL_CHRES])
        else $error("clear channel handled wrongly");
    chk_ack_len: assert property (
        (tx_o.start && !tx_o.from_buffer && r.st == maas_pkg::MAAS_ACK_TX)
        |-> tx_o.length == (tx_o.fcs32 ? maas_pkg::ACK_LEN_FCS32
                                       : maas_pkg::ACK_LEN_FCS16))
        else $error("self-built ack length wrong");
    chk_ack_delay: assert property (
        (r.st == maas_pkg::MAAS_ACK_WAIT && r.cnt == 16'h0002)
        |=> ##1 (r.cnt == '0) ##1 tx_o.start)
        else $error("ack delay miscounted");
    chk_transmit_then_receive: assert property (
        (tx_done_i && r.ctrl[maas_pkg::CTRL_TRANSMIT_THEN_RECEIVE]) |=> rx_enter_o)
        else $error("no receive entry after tx");
    chk_ed_start: assert property (
        ed_start_o |-> $past(r.ctrl[maas_pkg::CTRL_ENERGY_DETECT_AUTO_TRANSMIT]) && $past(wr_i))
        else $error("measurement started without request");
    chk_ack_gate: assert property (
        $rose(r.st == maas_pkg::MAAS_ACK_WAIT)
        |-> $past(r.ctrl[maas_pkg::CTRL_AUTO_ACK_ENABLE]) && $past(filt_on))
        else $error("ack started while disabled");
    chk_ack_transmit_frame_end_irq: assert property (
        (r.st == maas_pkg::MAAS_ACK_TX && tx_done_i)
        |=> transmit_frame_end_irq_o && !tx_o.phr_override)
        else $error("ack end irq missing");

    cov_ack: cover property (@(posedge clk_i) r.st == maas_pkg::MAAS_ACK_TX);
    cov_busy: cover property (@(posedge clk_i)
        r.st == maas_pkg::MAAS_ED_RUN ##1 r.ctrl[maas_pkg::CTRL_CHRES]);
    cov_clear: cover property (@(posedge clk_i) r.st == maas_pkg::MAAS_CCA_TX);

endmodule

`default_nettype wire

// ==== testbench/maas_radio_model.sv ====
// Purpose: radio front end model facing the mac helper sequencer
// Assumes: one clock; transmit and energy measurement take fixed cycles
// Notes:   measured value is not held outside its strobe, so a late read
//          of it by the sequencer shows a changing pattern
`timescale 1ns/10ps
`default_nettype none
module maas_radio_model #(
    parameter int TX_CYC = 6,
    parameter int ED_CYC = 4
) (
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire maas_pkg::maas_tx_t tx_i,
    input  wire logic               ext_tx_i,
    input  wire logic               ed_start_i,
    input  wire logic [7:0]         energy_i,
    output var  logic               tx_done_o,
    output var  logic               ed_done_o,
    output var  logic [7:0]         ed_value_o
);
    int tx_cnt;
    int ed_cnt;
    always @(posedge clk_i) begin
        tx_done_o <= 1'b0;
        ed_done_o <= 1'b0;
        ed_value_o <= ~ed_value_o;
        if (rst_i) begin
            tx_cnt <= 0;
            ed_cnt <= 0;
            ed_value_o <= 8'h5A;
        end else begin
            if (tx_i.start || ext_tx_i) begin
                tx_cnt <= TX_CYC;
            end else if (tx_cnt > 0) begin
                tx_cnt <= tx_cnt - 1;
                tx_done_o <= (tx_cnt == 1);
            end
            if (ed_start_i) begin
                ed_cnt <= ED_CYC;
            end else if (ed_cnt > 0) begin
                ed_cnt <= ed_cnt - 1;
                ed_done_o <= (ed_cnt == 1);
                ed_value_o <= energy_i;
            end
        end
    end
endmodule
`default_nettype wire

// ==== testbench/maas_seq_tb.sv ====
// Purpose: self-checking bench for the mac helper sequencer
// Assumes: host side is the bench, radio side is the radio model
// Notes:   event times are counted in cycles after the taking edge
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin \
    fails++; $display("MISMATCH %s exp %0h got %0h", nm, ex, gt); end end
module maas_seq_tb;
    logic               clk_i = 1'b0;
    logic               rst_i = 1'b1;
    logic [7:0]         addr_i = 8'h00;
    logic [7:0]         wdata_i = 8'h00;
    logic               wr_i = 1'b0;
    logic               rd_i = 1'b0;
    logic               in_rx = 1'b1;
    logic               ext_tx = 1'b0;
    logic [7:0]         energy = 8'h00;
    maas_pkg::maas_rx_t rx_i = '0;
    maas_pkg::maas_tx_t tx_o;
    maas_pkg::maas_tx_t txc;
    logic [7:0]         rdata_o;
    logic [7:0]         ed_value;
    logic               tx_done, ed_done, ed_start, rx_enter, rxfe, transmit_frame_end_irq;
    logic               edc, rdy, prep, bb, prom;
    logic [3:0]         fen;
    logic [7:0]         d;
    logic               p1;
    int fails = 0;
    int comparisons = 0;
    int a_st, a_rxfe, a_transmit_frame_end_irq, a_edc, a_rdy, a_eds, a_rxen;

    always #20 clk_i = ~clk_i;

    maas_seq #(.DELAY_W(16)) uut (
        .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rx_i(rx_i),
        .in_rx_state_i(in_rx), .tx_done_i(tx_done), .ed_done_i(ed_done),
        .ed_value_i(ed_value), .tx_o(tx_o), .ed_start_o(ed_start),
        .rx_enter_o(rx_enter), .rx_frame_end_irq_o(rxfe),
        .transmit_frame_end_irq_o(transmit_frame_end_irq), .measurement_done_irq_o(edc),
        .transceiver_ready_irq_o(rdy), .transmit_prepare_state_o(prep),
        .baseband_enable_o(bb), .promiscuous_select_o(prom),
        .filter_unit_enable_o(fen));

    maas_radio_model radio (
        .clk_i(clk_i), .rst_i(rst_i), .tx_i(tx_o), .ext_tx_i(ext_tx),
        .ed_start_i(ed_start), .energy_i(energy), .tx_done_o(tx_done),
        .ed_done_o(ed_done), .ed_value_o(ed_value));

    // records the first cycle of each pulse; also ends one-cycle strobes
    task automatic run(input int n);
        {a_st, a_rxfe, a_transmit_frame_end_irq, a_edc, a_rdy, a_eds, a_rxen} = '0;
        for (int i = 1; i <= n; i++) begin
            @(posedge clk_i);
            rx_i.frame_end <= 1'b0;
            wr_i <= 1'b0;
            ext_tx <= 1'b0;
            #1;
            if (tx_o.start && a_st == 0) txc = tx_o;
            if (tx_o.start && a_st == 0) a_st = i;
            if (rxfe && a_rxfe == 0) p1 = prep;
            if (rxfe && a_rxfe == 0) a_rxfe = i;
            if (transmit_frame_end_irq && a_transmit_frame_end_irq == 0) a_transmit_frame_end_irq = i;
            if (edc && a_edc == 0) a_edc = i;
            if (rdy && a_rdy == 0) a_rdy = i;
            if (ed_start && a_eds == 0) a_eds = i;
            if (rx_enter && a_rxen == 0) a_rxen = i;
        end
    endtask

    task automatic put(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        put(a, v);
        run(1);
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask

    task automatic frame(input logic ps, input logic [2:0] ft,
                         input logic ar, input logic [3:0] um,
                         input logic [7:0] sq, input logic f32,
                         input logic [7:0] ph, input int n);
        @(posedge clk_i);
        rx_i <= '{1'b1, ps, ft, ar, um, sq, f32, ph};
        run(n);
    endtask

    task automatic t_regs();
        rd(maas_pkg::ADDR_CTRL);
        `CHK("ctrl reset", maas_pkg::RESET_BYTE, d)
        wr(maas_pkg::ADDR_AFC0, 8'h1A);
        `CHK("promiscuous on", 1'b1, prom)
        `CHK("unit enables", 4'hA, fen)
        wr(maas_pkg::ADDR_AFC0, 8'h05);
        `CHK("promiscuous off", 1'b0, prom)
        `CHK("unit enables", 4'h5, fen)
        rd(maas_pkg::ADDR_AFC0);
        `CHK("filter cfg read", 8'h05, d)
        // no forbidden procedure pair is switched on together
        wr(maas_pkg::ADDR_CTRL, 8'h7C);
        rd(maas_pkg::ADDR_CTRL);
        `CHK("ctrl result bit read only", 8'h78, d)
        rd(8'hFF);
        `CHK("unmapped read", 8'h00, d)
    endtask

    // self-built ack: long delay spanning both delay bytes
    task automatic t_ack_self();
        wr(maas_pkg::ADDR_AFC0, 8'h0F);
        wr(maas_pkg::ADDR_CTRL, 8'h08);
        wr(maas_pkg::ADDR_ACK_DL, 8'h05);
        wr(maas_pkg::ADDR_ACK_DH, 8'h01);
        wr(maas_pkg::ADDR_ACK_PD, 8'h04);
        frame(1'b1, maas_pkg::FT_DATA, 1'b1, 4'h4, 8'hA7, 1'b0, 8'h00, 300);
        `CHK("rx end time", 1, a_rxfe)
        `CHK("prepare at rx end", 1'b1, p1)
        `CHK("ack start time", 263, a_st)
        `CHK("ack length", maas_pkg::ACK_LEN_FCS16, txc.length)
        `CHK("ack seq", 8'hA7, txc.seq_num)
        `CHK("ack self built", 1'b0, txc.from_buffer)
        `CHK("ack pending", 1'b1, txc.pending)
        `CHK("no override", 1'b0, txc.phr_override)
        `CHK("tx end after ack", 1'b1, a_transmit_frame_end_irq > a_st)
        wr(maas_pkg::ADDR_CTRL, 8'h48);
        wr(maas_pkg::ADDR_ACK_DL, 8'h02);
        wr(maas_pkg::ADDR_ACK_DH, 8'h00);
        frame(1'b1, maas_pkg::FT_CMD, 1'b1, 4'h2, 8'h3C, 1'b1, 8'h00, 30);
        `CHK("short start time", 4, a_st)
        `CHK("ack length 32", maas_pkg::ACK_LEN_FCS32, txc.length)
        `CHK("checksum follows", 1'b1, txc.fcs32)
        `CHK("pending other unit", 1'b0, txc.pending)
    endtask

    // frames that must not be acknowledged, and one that must not end
    task automatic t_no_ack();
        frame(1'b1, 3'h0, 1'b1, 4'h1, 8'h11, 1'b0, 8'h00, 30);
        `CHK("beacon rx end", 1, a_rxfe)
        `CHK("beacon in prepare", 1'b1, p1)
        `CHK("beacon no ack", 0, a_st)
        frame(1'b1, maas_pkg::FT_DATA, 1'b0, 4'h1, 8'h12, 1'b0, 8'h00, 30);
        `CHK("no request no ack", 0, a_st)
        frame(1'b0, maas_pkg::FT_DATA, 1'b1, 4'h1, 8'h13, 1'b0, 8'h00, 30);
        `CHK("failed frame no rx end", 0, a_rxfe)
        `CHK("failed frame no ack", 0, a_st)
        wr(maas_pkg::ADDR_AFC0, 8'h00);
        frame(1'b1, maas_pkg::FT_DATA, 1'b1, 4'h1, 8'h14, 1'b0, 8'h00, 30);
        `CHK("filter off no ack", 0, a_st)
        wr(maas_pkg::ADDR_AFC0, 8'h0F);
        wr(maas_pkg::ADDR_CTRL, 8'h00);
        frame(1'b1, maas_pkg::FT_DATA, 1'b1, 4'h1, 8'h15, 1'b0, 8'h00, 30);
        `CHK("auto ack off no ack", 0, a_st)
    endtask

    // buffer ack with rate adaptation; host loads the buffer in time
    task automatic t_ack_buf();
        wr(maas_pkg::ADDR_TXLEN_L, 8'h34);
        wr(maas_pkg::ADDR_TXLEN_H, 8'h05);
        wr(maas_pkg::ADDR_CTRL, 8'h38);
        frame(1'b1, maas_pkg::FT_DATA, 1'b1, 4'h1, 8'h21, 1'b1, 8'hC3, 30);
        `CHK("buffer ack", 1'b1, txc.from_buffer)
        `CHK("buffer length", 11'h534, txc.length)
        `CHK("override on", 1'b1, txc.phr_override)
        `CHK("override restored", 1'b0, tx_o.phr_override)
        `CHK("phy copy", 8'hC3, txc.phr)
        `CHK("no checksum adapt", 1'b0, txc.fcs32)
    endtask

    task automatic t_cca();
        wr(maas_pkg::ADDR_CTRL, 8'h02);
        wr(maas_pkg::ADDR_THRESH, 8'h40);
        wr(maas_pkg::ADDR_BB, 8'h00);
        in_rx <= 1'b0;
        put(maas_pkg::ADDR_ED_MODE, maas_pkg::ED_MODE_SINGLE);
        run(20);
        `CHK("no measure outside rx", 0, a_eds)
        in_rx <= 1'b1;
        energy <= 8'h41;
        put(maas_pkg::ADDR_ED_MODE, maas_pkg::ED_MODE_SINGLE);
        run(20);
        `CHK("measure start", 1, a_eds)
        `CHK("busy tx end", a_edc, a_transmit_frame_end_irq)
        `CHK("busy no tx", 0, a_st)
        rd(maas_pkg::ADDR_CTRL);
        `CHK("busy flag", 1'b1, d[maas_pkg::CTRL_CHRES])
        `CHK("baseband stays off", 1'b0, bb)
        wr(maas_pkg::ADDR_BB, 8'h01);
        wr(maas_pkg::ADDR_BB, 8'h00);
        energy <= 8'h40;
        put(maas_pkg::ADDR_ED_MODE, maas_pkg::ED_MODE_SINGLE);
        run(30);
        `CHK("done irq", 1'b1, a_edc > a_eds)
        `CHK("ready at prepare", a_edc, a_rdy)
        `CHK("clear tx start", a_edc, a_st)
        `CHK("buffered frame", 1'b1, txc.from_buffer)
        `CHK("clear tx end", 1'b1, a_transmit_frame_end_irq > a_st)
        `CHK("baseband back on", 1'b1, bb)
        rd(maas_pkg::ADDR_CTRL);
        `CHK("clear flag", 1'b0, d[maas_pkg::CTRL_CHRES])
    endtask

    // host-made transmissions; the host times any ack wait itself
    task automatic t_transmit_then_receive();
        wr(maas_pkg::ADDR_CTRL, 8'h00);
        ext_tx <= 1'b1;
        run(15);
        `CHK("no switch when off", 0, a_rxen)
        wr(maas_pkg::ADDR_CTRL, 8'h01);
        ext_tx <= 1'b1;
        run(15);
        `CHK("switch to receive", 8, a_rxen)
    endtask

    task automatic summarize();
        if (fails == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        #(40 * 20000);
        fails++;
        summarize();
    end

    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_ack_self();
        t_no_ack();
        t_ack_buf();
        t_cca();
        t_transmit_then_receive();
        summarize();
    end
endmodule
`default_nettype wire
